// [hw/ssf_cap_if.sv]
// word and toggle handed from a link capture to the system clock side
`timescale 1ns/1ps
interface ssf_cap_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic         toggle;
	modport cap (output data, output toggle);
	modport sys (input data, input toggle);
endinterface

// [hw/ssf_link_cap.sv]
// captures a word on each rising edge of a link clock and flips a toggle
`timescale 1ns/1ps
module ssf_link_cap #(
	parameter int W = 8
) (
	input  wire logic         link_clk, // capture clock, inverted by the parent only where falling edge capture is wanted
	input  wire logic         rst_b,    // system reset, resynchronised here
	input  wire logic [W-1:0] din,      // pins captured on each rising edge
	ssf_cap_if.cap            cap       // to the system clock side
);
	logic [W-1:0] data_r;
	logic [W-1:0] data_nxt;
	logic         toggle_r;
	logic         toggle_nxt;
	logic         rst_meta_b_r;
	logic         rst_sync_b_r;

	initial
	begin
		if (W < 1)
			$error("ssf_link_cap: W must be at least 1");
	end

	always_comb
	begin
		data_nxt   = din;
		toggle_nxt = rst_sync_b_r ? ~toggle_r : 1'b0;
	end

	always_ff @(posedge link_clk)
	begin
		rst_meta_b_r <= rst_b;
		rst_sync_b_r <= rst_meta_b_r;
		data_r       <= data_nxt;
		toggle_r     <= toggle_nxt;
	end

	assign cap.data   = data_r;
	assign cap.toggle = toggle_r;
endmodule

// [hw/ssf_pkg.sv]
// constants shared by the shared pin function select block
package ssf_pkg;
	localparam logic [15:0] LINE_DRIVE_CTRL_CH3_ADDR = 16'h4f80;
	localparam logic [15:0] IO_CTRL_CH10_ADDR        = 16'hbf01;
	localparam int          GEN_OUT_LEVEL_POS        = 1;
	localparam int          CLK_EDGE_INVERT_POS      = 1;
	localparam logic [7:0]  LINE_DRIVE_CTRL_RESET    = 8'h00;
	localparam logic [7:0]  IO_CTRL_RESET            = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ_VALUE      = 8'h00;
	localparam int          ADD_BUS_WIDTH            = 8;
	localparam int          SYNC_STAGES              = 2;
endpackage

// [hw/ssf_shared_pin_select.sv]
// function select for the two shared add bus / line side pins
// How it works
// - channel 2 bus enabled: shared pin is add bus bit 7 beside bits 6..0.
// - channel 2 add bus bits are captured on falling edge of its bus clock.
// - channel 2 bus disabled: pin is channel 10 line clock, falling edge default.
// - edge invert bit 1 of channel 10 io control selects rising edge capture.
// - in STS-1 mode channel 10 always captures on the falling edge.
// - channel 3 bus enabled: shared pin is add bus bit 0, the byte's LSB.
// - channel 3 add bus bits are captured on falling edge of its bus clock.
// - channel 3 bus disabled: pin drives bit 1 of channel 3 line drive register.
`timescale 1ns/1ps
module ssf_shared_pin_select #(
	parameter int BUS_W = ssf_pkg::ADD_BUS_WIDTH
) (
	input  wire logic             clock,              // system clock, 200 MHz
	input  wire logic             rst_b,              // synchronous reset, active low
	input  wire logic             add_bus_en_ch2,     // channel 2 add bus enabled
	input  wire logic             add_bus_en_ch3,     // channel 3 add bus enabled
	input  wire logic             sts1_mode_ch10,     // channel 10 runs STS-1
	input  wire logic [15:0]      reg_addr,           // register address
	input  wire logic [7:0]       reg_wr_data,        // register write data
	input  wire logic             reg_wr,             // write strobe, one cycle
	input  wire logic             reg_rd,             // read strobe, one cycle
	output logic      [7:0]       reg_rd_data,        // read data, one cycle after strobe
	input  wire logic             add_bus_clock_ch2,  // channel 2 add bus clock
	input  wire logic [BUS_W-2:0] add_bus_ch2_low,    // channel 2 bus bits 6..0
	input  wire logic             add_bus_ch2_bit7,   // shared pin: bit 7 or ch10 line clock
	input  wire logic             line_rx_data_ch10,  // channel 10 line data
	input  wire logic             add_bus_clock_ch3,  // channel 3 add bus clock
	input  wire logic [BUS_W-1:1] add_bus_ch3_high,   // channel 3 bus bits 7..1
	input  wire logic             add_bus_ch3_bit0_i, // shared pin level in
	output logic                  add_bus_ch3_bit0_o, // shared pin level out
	output logic                  add_bus_ch3_bit0_oe_b, // low while driving
	output logic      [BUS_W-1:0] add_byte_ch2,       // captured channel 2 byte
	output logic                  add_byte_ch2_vld,   // pulse, new channel 2 byte
	output logic      [BUS_W-1:0] add_byte_ch3,       // captured channel 3 byte
	output logic                  add_byte_ch3_vld,   // pulse, new channel 3 byte
	output logic                  line_bit_ch10,      // captured channel 10 bit
	output logic                  line_bit_ch10_vld   // pulse, new channel 10 bit
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
	} ssf_sync_t;

	logic [7:0]       line_drive_r;
	logic [7:0]       line_drive_nxt;
	logic [7:0]       io_ctrl_r;
	logic [7:0]       io_ctrl_nxt;
	logic [7:0]       rd_data_r;
	logic [7:0]       rd_data_nxt;
	logic             gen_out_r;
	logic             gen_out_nxt;
	logic             oe_b_r;
	logic             oe_b_nxt;
	ssf_sync_t        tg_r [4];
	ssf_sync_t        tg_nxt [4];
	logic [BUS_W-1:0] byte2_r;
	logic [BUS_W-1:0] byte2_nxt;
	logic [BUS_W-1:0] byte3_r;
	logic [BUS_W-1:0] byte3_nxt;
	logic             bit10_r;
	logic             bit10_nxt;
	logic             vld2_r;
	logic             vld2_nxt;
	logic             vld3_r;
	logic             vld3_nxt;
	logic             vld10_r;
	logic             vld10_nxt;
	logic [3:0]       seen;
	logic             use_rise;
	logic             ch10_clk_fall;
	logic             ch2_clk_fall;
	logic             ch3_clk_fall;

	ssf_cap_if #(.W(BUS_W)) cap2 ();
	ssf_cap_if #(.W(BUS_W)) cap3 ();
	ssf_cap_if #(.W(1))     cap10f ();
	ssf_cap_if #(.W(1))     cap10r ();

	initial
	begin
		if (BUS_W != ssf_pkg::ADD_BUS_WIDTH)
			$error("ssf_shared_pin_select: add bus must be 8 bits wide");
	end

	function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] off);
		addr_hit = (a == off);
	endfunction

	assign ch2_clk_fall  = ~add_bus_clock_ch2;
	assign ch3_clk_fall  = ~add_bus_clock_ch3;
	assign ch10_clk_fall = ~add_bus_ch2_bit7;

	// shared pin sits at the top of the channel 2 byte
	ssf_link_cap #(.W(BUS_W)) u_cap2 (
		.link_clk (ch2_clk_fall),
		.rst_b    (rst_b),
		.din      ({add_bus_ch2_bit7, add_bus_ch2_low}),
		.cap      (cap2.cap)
	);

	// shared pin sits at the bottom of the channel 3 byte
	ssf_link_cap #(.W(BUS_W)) u_cap3 (
		.link_clk (ch3_clk_fall),
		.rst_b    (rst_b),
		.din      ({add_bus_ch3_high, add_bus_ch3_bit0_i}),
		.cap      (cap3.cap)
	);

	ssf_link_cap #(.W(1)) u_cap10f (
		.link_clk (ch10_clk_fall),
		.rst_b    (rst_b),
		.din      (line_rx_data_ch10),
		.cap      (cap10f.cap)
	);

	ssf_link_cap #(.W(1)) u_cap10r (
		.link_clk (add_bus_ch2_bit7),
		.rst_b    (rst_b),
		.din      (line_rx_data_ch10),
		.cap      (cap10r.cap)
	);

	// rising edge only for DS3/E3, STS-1 stays on falling
	assign use_rise = io_ctrl_r[ssf_pkg::CLK_EDGE_INVERT_POS] & ~sts1_mode_ch10;

	always_comb
	begin
		line_drive_nxt = line_drive_r;
		io_ctrl_nxt    = io_ctrl_r;
		rd_data_nxt    = rd_data_r;
		if (reg_wr && addr_hit(reg_addr, ssf_pkg::LINE_DRIVE_CTRL_CH3_ADDR))
			line_drive_nxt = reg_wr_data;
		if (reg_wr && addr_hit(reg_addr, ssf_pkg::IO_CTRL_CH10_ADDR))
			io_ctrl_nxt = reg_wr_data;
		if (reg_rd)
		begin
			if (addr_hit(reg_addr, ssf_pkg::LINE_DRIVE_CTRL_CH3_ADDR))
				rd_data_nxt = line_drive_r;
			else if (addr_hit(reg_addr, ssf_pkg::IO_CTRL_CH10_ADDR))
				rd_data_nxt = io_ctrl_r;
			else
				rd_data_nxt = ssf_pkg::UNMAPPED_READ_VALUE;
		end
		if (!rst_b)
		begin
			line_drive_nxt = ssf_pkg::LINE_DRIVE_CTRL_RESET;
			io_ctrl_nxt    = ssf_pkg::IO_CTRL_RESET;
			rd_data_nxt    = 8'h00;
		end
	end

	always_ff @(posedge clock)
	begin
		line_drive_r <= line_drive_nxt;
		io_ctrl_r    <= io_ctrl_nxt;
		rd_data_r    <= rd_data_nxt;
	end

	// general purpose output on the channel 3 shared pin
	always_comb
	begin
		gen_out_nxt = line_drive_r[ssf_pkg::GEN_OUT_LEVEL_POS];
		oe_b_nxt    = add_bus_en_ch3;
		if (!rst_b)
		begin
			gen_out_nxt = 1'b0;
			oe_b_nxt    = 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		gen_out_r <= gen_out_nxt;
		oe_b_r    <= oe_b_nxt;
	end

	// toggle synchronisers and word transfer into the system clock
	always_comb
	begin
		tg_nxt[0].meta = cap2.toggle;
		tg_nxt[1].meta = cap3.toggle;
		tg_nxt[2].meta = cap10f.toggle;
		tg_nxt[3].meta = cap10r.toggle;
		for (int i = 0; i < 4; i++)
		begin
			tg_nxt[i].sync = tg_r[i].meta;
			tg_nxt[i].last = tg_r[i].sync;
			seen[i]        = tg_r[i].sync ^ tg_r[i].last;
		end
		byte2_nxt = byte2_r;
		byte3_nxt = byte3_r;
		bit10_nxt = bit10_r;
		vld2_nxt  = seen[0] & add_bus_en_ch2;
		vld3_nxt  = seen[1] & add_bus_en_ch3;
		vld10_nxt = ~add_bus_en_ch2 & (use_rise ? seen[3] : seen[2]);
		if (vld2_nxt)
			byte2_nxt = cap2.data;
		if (vld3_nxt)
			byte3_nxt = cap3.data;
		if (vld10_nxt)
			bit10_nxt = use_rise ? cap10r.data[0] : cap10f.data[0];
		if (!rst_b)
		begin
			for (int i = 0; i < 4; i++)
				tg_nxt[i] = '0;
			byte2_nxt = '0;
			byte3_nxt = '0;
			bit10_nxt = 1'b0;
			vld2_nxt  = 1'b0;
			vld3_nxt  = 1'b0;
			vld10_nxt = 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		tg_r    <= tg_nxt;
		byte2_r <= byte2_nxt;
		byte3_r <= byte3_nxt;
		bit10_r <= bit10_nxt;
		vld2_r  <= vld2_nxt;
		vld3_r  <= vld3_nxt;
		vld10_r <= vld10_nxt;
	end

	assign reg_rd_data           = rd_data_r;
	assign add_bus_ch3_bit0_o    = gen_out_r;
	assign add_bus_ch3_bit0_oe_b = oe_b_r;
	assign add_byte_ch2          = byte2_r;
	assign add_byte_ch2_vld      = vld2_r;
	assign add_byte_ch3          = byte3_r;
	assign add_byte_ch3_vld      = vld3_r;
	assign line_bit_ch10         = bit10_r;
	assign line_bit_ch10_vld     = vld10_r;
endmodule

// [tb/ssf_far_end.sv]
// far side model: link clock and bus data, clock still between frames
`timescale 1ns/1ps
module ssf_far_end #(
	parameter int W = 8
) (
	output logic         lclk, // link clock, idle low
	output logic [W-1:0] ldat  // bus or line data
);
	initial
	begin
		lclk = 1'b0;
		ldat = '0;
	end
	// a stands at the rising edge, b at the falling edge
	task automatic send(input logic [W-1:0] a, input logic [W-1:0] b);
		ldat = a;
		#62.5 lclk = 1'b1;
		#31 ldat = b;
		#31.5 lclk = 1'b0;
		#31 ldat = ~b;
		#31.5;
	endtask
endmodule

// [tb/ssf_shared_pin_select_sva.sv]
// checker on the shared pin select ports
`timescale 1ns/1ps
module ssf_shared_pin_select_sva (
	input wire logic        clock,                 // clock
	input wire logic        rst_b,                 // reset
	input wire logic        add_bus_en_ch2,        // ch2 on
	input wire logic        add_bus_en_ch3,        // ch3 on
	input wire logic [15:0] reg_addr,              // address
	input wire logic [7:0]  reg_wr_data,           // write data
	input wire logic        reg_wr,                // write
	input wire logic        reg_rd,                // read
	input wire logic [7:0]  reg_rd_data,           // read data
	input wire logic        add_bus_ch3_bit0_o,    // pin level
	input wire logic        add_bus_ch3_bit0_oe_b, // pin enable
	input wire logic        add_byte_ch2_vld,      // ch2 byte
	input wire logic        add_byte_ch3_vld,      // ch3 byte
	input wire logic        line_bit_ch10_vld      // ch10 bit
);
	localparam logic [15:0] DRV = ssf_pkg::LINE_DRIVE_CTRL_CH3_ADDR;
	localparam logic [15:0] IOC = ssf_pkg::IO_CTRL_CH10_ADDR;
	wire logic lvl = reg_wr_data[ssf_pkg::GEN_OUT_LEVEL_POS];
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_oe_off_bus: assert property (rst_b && add_bus_en_ch3 |=> add_bus_ch3_bit0_oe_b)
		else $error("pin driven while ch3 bus on");
	a_oe_on_free: assert property (rst_b && !add_bus_en_ch3 |=> !add_bus_ch3_bit0_oe_b)
		else $error("pin not driven while ch3 bus off");
	a_pin_from_reg: assert property (reg_wr && reg_addr == DRV |-> ##2
		add_bus_ch3_bit0_o == $past(lvl, 2)) else $error("pin level wrong");
	a_unmapped_zero: assert property (reg_rd && reg_addr != DRV && reg_addr != IOC
		|=> reg_rd_data == 8'h00) else $error("unmapped read not zero");
	a_io_readback: assert property (reg_wr && reg_addr == IOC ##1 reg_rd && reg_addr == IOC
		|=> reg_rd_data == $past(reg_wr_data, 2)) else $error("io control readback");
	a_ch2_gate: assert property (add_byte_ch2_vld |-> add_bus_en_ch2)
		else $error("ch2 byte while bus off");
	a_ch3_gate: assert property (add_byte_ch3_vld |-> add_bus_en_ch3)
		else $error("ch3 byte while bus off");
	a_ch10_gate: assert property (line_bit_ch10_vld |-> !add_bus_en_ch2)
		else $error("ch10 bit while ch2 bus on");
	c_ch2: cover property (add_byte_ch2_vld);
	c_ch3: cover property (add_byte_ch3_vld);
	c_ch10: cover property (line_bit_ch10_vld);
endmodule
bind ssf_shared_pin_select ssf_shared_pin_select_sva i_ssf_shared_pin_select_sva (
	.clock, .rst_b, .add_bus_en_ch2, .add_bus_en_ch3, .reg_addr, .reg_wr_data, .reg_wr,
	.reg_rd, .reg_rd_data, .add_bus_ch3_bit0_o, .add_bus_ch3_bit0_oe_b, .add_byte_ch2_vld,
	.add_byte_ch3_vld, .line_bit_ch10_vld);

// [tb/tb_shared_pin_function_select.sv]
// testbench for the shared pin select block
`timescale 1ns/1ps
module tb_shared_pin_function_select;
	localparam logic [15:0] DRV = ssf_pkg::LINE_DRIVE_CTRL_CH3_ADDR;
	localparam logic [15:0] IOC = ssf_pkg::IO_CTRL_CH10_ADDR;
	logic        clock, rst_b, en2, en3, sts1, reg_wr, reg_rd, mon_on, rd_p;
	logic        c2, c3, c10, bit7, pin_o, oe_b, pin_i, v2, v3, v10, bit10;
	logic [15:0] reg_addr;
	logic [7:0]  reg_wr_data, reg_rd_data, byte2, byte3, d2, d3, a, b;
	logic [0:0]  d10;
	logic [7:0]  q2[$], q3[$], q10[$], qr[$];
	int          n_mismatch = 0;
	int          checked = 0;
	assign bit7 = en2 ? d2[7] : c10;
	assign pin_i = oe_b ? d3[0] : pin_o;
	ssf_shared_pin_select i_ssf_shared_pin_select (
		.clock, .rst_b, .add_bus_en_ch2(en2), .add_bus_en_ch3(en3), .sts1_mode_ch10(sts1),
		.reg_addr, .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data, .add_bus_clock_ch2(c2),
		.add_bus_ch2_low(d2[6:0]), .add_bus_ch2_bit7(bit7), .line_rx_data_ch10(d10[0]),
		.add_bus_clock_ch3(c3), .add_bus_ch3_high(d3[7:1]), .add_bus_ch3_bit0_i(pin_i),
		.add_bus_ch3_bit0_o(pin_o), .add_bus_ch3_bit0_oe_b(oe_b), .add_byte_ch2(byte2),
		.add_byte_ch2_vld(v2), .add_byte_ch3(byte3), .add_byte_ch3_vld(v3),
		.line_bit_ch10(bit10), .line_bit_ch10_vld(v10));
	ssf_far_end #(.W(8)) i_ssf_far_end_ch2 (.lclk(c2), .ldat(d2));
	ssf_far_end #(.W(8)) i_ssf_far_end_ch3 (.lclk(c3), .ldat(d3));
	ssf_far_end #(.W(1)) i_ssf_far_end_ch10 (.lclk(c10), .ldat(d10));
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] ad, input logic [7:0] d);
		reg_addr <= ad;
		reg_wr_data <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] ad, input logic [7:0] e);
		qr.push_back(e);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask
	task automatic warm();
		repeat (3)
		fork
			i_ssf_far_end_ch2.send(8'h00, 8'h00);
			i_ssf_far_end_ch3.send(8'h00, 8'h00);
			i_ssf_far_end_ch10.send(1'b0, 1'b0);
		join
		@(posedge clock);
	endtask
	task automatic print_verdict();
		if (n_mismatch == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock)
	begin
		rd_p <= reg_rd;
		if (rd_p) cmp("rd_data", qr.size() ? qr.pop_front() : 8'hxx, reg_rd_data);
		if (mon_on && v2) cmp("ch2", q2.size() ? q2.pop_front() : 8'hxx, byte2);
		if (mon_on && v3) cmp("ch3", q3.size() ? q3.pop_front() : 8'hxx, byte3);
		if (mon_on && v10) cmp("ch10", q10.size() ? q10.pop_front() : 8'hxx, {7'h00, bit10});
	end
	initial
	begin
		#50000;
		n_mismatch++;
		print_verdict();
	end
	initial
	begin
		{rst_b, en2, en3, sts1, reg_wr, reg_rd, mon_on, rd_p} = '0;
		reg_addr = '0;
		reg_wr_data = '0;
		void'($urandom(32'haaa2));
		repeat (3) @(posedge clock);
		warm();
		rst_b <= 1'b1;
		warm();
		mon_on <= 1'b1;
		rd(DRV, 8'h00);
		rd(IOC, 8'h00);
		a = $urandom;
		wr(DRV, a);
		rd(DRV, a);
		wr(16'h4f81, 8'hff);
		rd(16'h4f81, 8'h00);
		for (int m = 0; m < 4; m++)
		begin
			sts1 <= m[1];
			a = $urandom;
			wr(IOC, {a[7:2], m[0], a[0]});
			rd(IOC, {a[7:2], m[0], a[0]});
			q10.push_back({7'h00, (m == 1) ? a[0] : ~a[0]});
			i_ssf_far_end_ch10.send(a[0], ~a[0]);
			@(posedge clock);
		end
		en2 <= 1'b1;
		repeat (4)
		begin
			@(posedge clock);
			a = $urandom;
			b = $urandom;
			q2.push_back(b);
			i_ssf_far_end_ch2.send(a, b);
		end
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clock);
			en3 <= 1'b0;
			wr(DRV, k[0] ? 8'h02 : 8'hfd);
			repeat (2) @(posedge clock);
			#1 cmp("pin", {7'h00, k[0]}, {6'h00, oe_b, pin_o});
			i_ssf_far_end_ch3.send(8'hff, 8'hff);
			@(posedge clock);
			en3 <= 1'b1;
			a = $urandom;
			b = $urandom;
			q3.push_back(b);
			i_ssf_far_end_ch3.send(a, b);
			#1 cmp("oe_b", 8'h01, {7'h00, oe_b});
		end
		repeat (20) @(posedge clock);
		cmp("left", 8'h00, 8'(q2.size() + q3.size() + q10.size() + qr.size()));
		print_verdict();
	end
endmodule
